// ### logic/wdcl_count_load.v
// Notes on behaviour
// - The count register is read-only, shows the live down-counter and resets to all ones.
// - Reading the lowest count byte captures all 32 counter bits so upper-byte reads stay consistent.
// - The count register spans byte addresses 0x3004 (bits 7:0) to 0x3007 (bits 31:24).
// - Writing the reload register loads the new value into the counter; the reload register resets to all ones.
// - The reload value can change only while the enable bit is 0, and software disables first.
// - The reload register spans byte addresses 0x3008 (bits 7:0) to 0x300b (bits 31:24).
// - Setting the enable bit starts the down-counter and clearing it stops it.
// - A kick while enabled reloads the counter from the reload register; a kick while disabled does nothing.
// - Underflow requests a device reset and sets a sticky flag that software clears by writing one.
`timescale 1ns/1ps
`include "wdcl_consts.vh"

module wdcl_count_load #(
  parameter TICKS_MS = `WDCL_UNIT_MS_NS / `WDCL_CLK_PERIOD_NS
) (
  // Clock and reset (power-on only; not driven by the watchdog reset)
  input  wire        clk_sys,
  input  wire        reset,
  // Byte register port
  input  wire [15:0] reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // Control bits held in the control and kick registers
  input  wire        timer_enable_bit,
  input  wire        units_us,
  input  wire        reload_trigger,
  input  wire        flag_write,
  input  wire        flag_write_data,
  // Status and reset request
  output reg         underflow_reset_flag,
  output reg         underflow_reset,
  output wire [31:0] counter_value
);

  localparam TICKS_US = `WDCL_UNIT_US_NS / `WDCL_CLK_PERIOD_NS;

  // ****************************************
  // Declarations
  // ****************************************
  reg  [31:0] counter;
  reg  [31:0] counter_snapshot;
  reg  [31:0] reload_value;
  reg  [31:0] next_counter;
  reg  [7:0]  next_rdata;
  reg         enable_q;

  wire [31:0] next_reload;
  wire        tick;
  wire        count_hit;
  wire        load_hit;
  wire [1:0]  lane;
  wire [3:0]  lane_hot;
  wire        load_write;
  wire        kick;
  wire        count_zero;
  wire        underflow;
  wire        unit_restart;
  wire        snap_take;
  genvar      gl;

  // ****************************************
  // Address decode
  // ****************************************
  function in_word;
    input [15:0] addr;
    input [15:0] base;
    begin
      in_word = ((addr & `WDCL_ADDR_MASK_WORD) == base);
    end
  endfunction

  function [7:0] pick_byte;
    input [31:0] word;
    input [1:0]  sel;
    begin
      pick_byte = word[sel*8 +: 8];
    end
  endfunction

  // Lanes outside the two words read as zero and drop writes
  assign count_hit  = in_word(reg_addr, `WDCL_ADDR_COUNT);
  assign load_hit   = in_word(reg_addr, `WDCL_ADDR_LOAD);
  assign lane       = reg_addr[1:0];
  assign lane_hot   = 4'h1 << lane;

  // ****************************************
  // Event decode
  // ****************************************
  // Locked while enabled so a running count cannot be retargeted
  assign load_write   = reg_wr && load_hit && !timer_enable_bit;
  // Kicks while stopped are dropped here, not queued
  assign kick         = reload_trigger && timer_enable_bit;
  // A zero count lasts one full unit before the underflow tick
  assign count_zero   = (counter == `WDCL_COUNT_ZERO);
  assign underflow    = timer_enable_bit && tick && count_zero;
  assign unit_restart = kick || (timer_enable_bit && !enable_q);
  assign snap_take    = reg_rd && count_hit && (lane == `WDCL_LANE_LOW);

  assign counter_value = counter;

  // ****************************************
  // Time base
  // ****************************************
  // Unit restarts on enable rise and on a kick, so each grants a full first unit
  wdcl_tick_div #(
    .CNT_W    (16),
    .TICKS_MS (TICKS_MS),
    .TICKS_US (TICKS_US)
  ) wdcl_tick_div_i (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .run      (timer_enable_bit),
    .restart  (unit_restart),
    .units_us (units_us),
    .tick     (tick)
  );

  // ****************************************
  // Reload register and down-counter
  // ****************************************
  // Each lane keeps its old byte unless this write targets it
  generate
    for (gl = 0; gl < 4; gl = gl + 1)
    begin : g_lane
      assign next_reload[gl*8 +: 8] = lane_hot[gl] ? reg_wdata : reload_value[gl*8 +: 8];
    end
  endgenerate

  // A reload write beats a kick, and a kick beats a tick
  always @*
  begin
    next_counter = counter;
    if (load_write)
      next_counter = next_reload;
    else if (kick || underflow)
      next_counter = reload_value;
    else if (timer_enable_bit && tick)
      next_counter = counter - 32'h00000001;
  end

  // Only power-on reset clears these; the watchdog reset stays outside
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      reload_value <= `WDCL_LOAD_RESET;
      counter      <= `WDCL_COUNT_RESET;
      enable_q     <= 1'b0;
    end
    else
    begin
      if (load_write)
        reload_value <= next_reload;
      counter  <= next_counter;
      enable_q <= timer_enable_bit;
    end
  end

  // ****************************************
  // Underflow reset request and sticky flag
  // ****************************************
  // Set beats a clear in the same cycle so an underflow is never lost
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      underflow_reset      <= 1'b0;
      underflow_reset_flag <= 1'b0;
    end
    else
    begin
      underflow_reset <= underflow;
      if (underflow)
        underflow_reset_flag <= 1'b1;
      else if (flag_write && flag_write_data)
        underflow_reset_flag <= 1'b0;
    end
  end

  // ****************************************
  // Read data select
  // ****************************************
  // Upper count bytes come from the copy so a moving count cannot tear
  always @*
  begin
    next_rdata = reg_rdata;
    if (snap_take)
      next_rdata = counter[7:0];
    else if (reg_rd && count_hit)
      next_rdata = pick_byte(counter_snapshot, lane);
    else if (reg_rd && load_hit)
      next_rdata = pick_byte(reload_value, lane);
    else if (reg_rd)
      next_rdata = `WDCL_READ_ZERO;
  end

  // ****************************************
  // Read data register and count snapshot
  // ****************************************
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      counter_snapshot <= `WDCL_COUNT_RESET;
      reg_rdata        <= `WDCL_READ_ZERO;
    end
    else
    begin
      if (snap_take)
        counter_snapshot <= counter;
      reg_rdata <= next_rdata;
    end
  end

endmodule

// ### logic/wdcl_consts.vh
`ifndef WDCL_CONSTS_VH
`define WDCL_CONSTS_VH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define WDCL_ADDR_COUNT      16'h3004
`define WDCL_ADDR_LOAD       16'h3008
`define WDCL_ADDR_MASK_WORD  16'hfffc
`define WDCL_COUNT_RESET     32'hffffffff
`define WDCL_LOAD_RESET      32'hffffffff
`define WDCL_READ_ZERO       8'h00
`define WDCL_COUNT_ZERO      32'h00000000
`define WDCL_LANE_LOW        2'h0

// ****************************************
// Timing
// ****************************************
`define WDCL_CLK_PERIOD_NS   100
`define WDCL_UNIT_MS_NS      1000000
`define WDCL_UNIT_US_NS      1000

`endif

// ### logic/wdcl_tick_div.v
`timescale 1ns/1ps

// ****************************************
// Time-base divider: one-cycle tick per timer unit
// ****************************************
module wdcl_tick_div #(
  parameter CNT_W    = 16,
  parameter TICKS_MS = 10000,
  parameter TICKS_US = 10
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             reset,
  // Control
  input  wire             run,
  input  wire             restart,
  input  wire             units_us,
  // Tick out
  output reg              tick
);

  localparam integer     LAST_MS_FULL = TICKS_MS - 1;
  localparam integer     LAST_US_FULL = TICKS_US - 1;
  localparam [CNT_W-1:0] LAST_MS      = LAST_MS_FULL[CNT_W-1:0];
  localparam [CNT_W-1:0] LAST_US      = LAST_US_FULL[CNT_W-1:0];

  reg  [CNT_W-1:0] count;
  wire [CNT_W-1:0] last;

  assign last = units_us ? LAST_US : LAST_MS;

  // Restart realigns the unit so a kick always grants a full first unit
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      count <= {CNT_W{1'b0}};
      tick  <= 1'b0;
    end
    else if (!run || restart)
    begin
      count <= {CNT_W{1'b0}};
      tick  <= 1'b0;
    end
    else if (count >= last)
    begin
      count <= {CNT_W{1'b0}};
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule

// ### sim/wdcl_host.sv
`timescale 1ns/1ps
// ***
// Host software on the byte port
// ***
module wdcl_host (
  // Bus
  input  wire        clk_sys,
  input  wire [7:0]  reg_rdata,
  output reg  [15:0] reg_addr = 16'h0,
  output reg         reg_wr = 1'b0,
  output reg         reg_rd = 1'b0,
  output reg  [7:0]  reg_wdata = 8'h0
);
  reg [7:0] q;
  task xfer(input w, input [15:0] a, input [7:0] d);
  begin
    @(posedge clk_sys) #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge clk_sys) #1;
    // Idle lines scrambled so stale values cannot pass
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    q = reg_rdata;
  end
  endtask
  task rd32(input [15:0] a, output [31:0] v);
    integer i;
  begin
    for (i = 0; i < 4; i = i + 1) // Lowest byte first
    begin
      xfer(1'b0, a + i[15:0], 8'h0);
      v[8*i +: 8] = q;
    end
  end
  endtask
  task wr32(input [31:0] v);
    integer i;
  begin
    for (i = 0; i < 4; i = i + 1)
      xfer(1'b1, 16'h3008 + i[15:0], v[8*i +: 8]);
  end
  endtask
endmodule

// ### sim/wdcl_count_load_props.sv
`timescale 1ns/1ps
// ***
// Port checker
// ***
module wdcl_props #(
  parameter TICKS_MS = 20
) (
  input wire        clk_sys,
  input wire        reset,
  input wire [15:0] reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_wdata,
  input wire [7:0]  reg_rdata,
  input wire        timer_enable_bit,
  input wire        reload_trigger,
  input wire        flag_write,
  input wire        flag_write_data,
  input wire        underflow_reset_flag,
  input wire        underflow_reset,
  input wire [31:0] counter_value
);
  // Own copies, so checks never lean on design state
  reg [31:0] snap;
  reg [31:0] ld;
  always @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      snap <= 32'hffffffff;
      ld   <= 32'hffffffff;
    end
    else
    begin
      if (reg_rd && reg_addr == 16'h3004)
        snap <= counter_value;
      if (reg_wr && !timer_enable_bit && reg_addr[15:2] == 14'h0c02)
        ld[8*reg_addr[1:0] +: 8] <= reg_wdata;
    end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  lsb_snap_a: assert property (reg_rd && reg_addr == 16'h3004 |=> reg_rdata == $past(counter_value[7:0]))
    else $error("low count byte wrong");
  upper_snap_a: assert property (reg_rd && reg_addr[15:2] == 14'h0c01 && reg_addr[1:0] != 2'h0
    |=> reg_rdata == $past(snap[8*reg_addr[1:0] +: 8])) else $error("upper count byte wrong");
  load_write_a: assert property (reg_wr && !timer_enable_bit && reg_addr[15:2] == 14'h0c02
    |=> counter_value[8*$past(reg_addr[1:0]) +: 8] == $past(reg_wdata)) else $error("reload not loaded");
  load_lock_a: assert property (reg_wr && timer_enable_bit && !reload_trigger && counter_value != 0
    |=> counter_value == $past(counter_value) || counter_value == $past(counter_value) - 1) else $error("locked");
  kick_load_a: assert property (reload_trigger && timer_enable_bit |=> counter_value == $past(ld))
    else $error("kick did not reload");
  stop_hold_a: assert property (!timer_enable_bit && $past(!timer_enable_bit) && !reg_wr
    |=> $stable(counter_value)) else $error("counter moved while stopped");
  uf_pulse_a: assert property (underflow_reset |-> underflow_reset_flag && $past(counter_value) == 0
    ##1 !underflow_reset) else $error("bad underflow pulse");
  flag_clear_a: assert property (flag_write && flag_write_data |=> !underflow_reset_flag || underflow_reset)
    else $error("flag not cleared");
  cover property (reload_trigger && timer_enable_bit);
  cover property (underflow_reset);
  cover property (reg_wr && timer_enable_bit);
endmodule
bind wdcl_count_load wdcl_props #(.TICKS_MS(TICKS_MS)) wdcl_props_i (
  .clk_sys              (clk_sys),
  .reset                (reset),
  .reg_addr             (reg_addr),
  .reg_wr               (reg_wr),
  .reg_rd               (reg_rd),
  .reg_wdata            (reg_wdata),
  .reg_rdata            (reg_rdata),
  .timer_enable_bit     (timer_enable_bit),
  .reload_trigger       (reload_trigger),
  .flag_write           (flag_write),
  .flag_write_data      (flag_write_data),
  .underflow_reset_flag (underflow_reset_flag),
  .underflow_reset      (underflow_reset),
  .counter_value        (counter_value)
);

// ### sim/test_wdcl_count_load.sv
`timescale 1ns/1ps
module test_wdcl_count_load;
  reg         clk_sys = 1'b0;
  reg         reset = 1'b1;
  reg         timer_enable_bit = 1'b0;
  reg         units_us = 1'b1;
  reg         reload_trigger = 1'b0;
  reg         flag_write = 1'b0;
  reg         flag_write_data = 1'b0;
  wire [15:0] reg_addr;
  wire        reg_wr, reg_rd, underflow_reset_flag, underflow_reset;
  wire [7:0]  reg_wdata, reg_rdata;
  wire [31:0] counter_value;
  integer     err_count = 0, tests_run = 0, cyc = 0, i;
  reg  [31:0] v, w;
  always #50 clk_sys = ~clk_sys;
  wdcl_count_load #(.TICKS_MS(20)) wdcl_count_load_i (
    .clk_sys              (clk_sys),
    .reset                (reset),
    .reg_addr             (reg_addr),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_wdata            (reg_wdata),
    .reg_rdata            (reg_rdata),
    .timer_enable_bit     (timer_enable_bit),
    .units_us             (units_us),
    .reload_trigger       (reload_trigger),
    .flag_write           (flag_write),
    .flag_write_data      (flag_write_data),
    .underflow_reset_flag (underflow_reset_flag),
    .underflow_reset      (underflow_reset),
    .counter_value        (counter_value)
  );
  wdcl_host wdcl_host_i (
    .clk_sys   (clk_sys),
    .reg_rdata (reg_rdata),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_wdata (reg_wdata)
  );
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task final_report;
  begin
    $display("mismatches=%0d checks=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  // Enable, kick, flag write, flag data
  task set(input [3:0] s);
  begin
    @(posedge clk_sys) #1;
    {timer_enable_bit, reload_trigger, flag_write, flag_write_data} = s;
  end
  endtask
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      err_count = err_count + 1;
      final_report;
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    #1 reset = 1'b0;
    wdcl_host_i.rd32(16'h3004, v);
    chk(v, 32'hffffffff);
    wdcl_host_i.rd32(16'h3008, v);
    chk(v, 32'hffffffff);
    wdcl_host_i.xfer(1'b0, 16'h300c, 8'h0);
    chk(wdcl_host_i.q, 32'h0);
    wdcl_host_i.wr32(32'h123); // Disabled, nonzero
    wdcl_host_i.xfer(1'b1, 16'h3005, 8'h55);
    wdcl_host_i.rd32(16'h3004, v);
    chk(v, 32'h123);
    set(4'h8);
    repeat (35) @(posedge clk_sys);
    wdcl_host_i.xfer(1'b1, 16'h3009, 8'h77);
    set(4'h0);
    wdcl_host_i.rd32(16'h3004, w);
    chk(w < 32'h123 && w > 32'h11e, 32'h1);
    wdcl_host_i.rd32(16'h3008, v);
    chk(v, 32'h123);
    set(4'h4);
    set(4'h0);
    wdcl_host_i.rd32(16'h3004, v);
    chk(v, w);
    set(4'hc);
    set(4'h0);
    wdcl_host_i.rd32(16'h3004, v);
    chk(v, 32'h123);
    wdcl_host_i.wr32(32'h2);
    // Upper byte alone must still come from the 0x123 capture
    wdcl_host_i.xfer(1'b0, 16'h3005, 8'h0);
    chk(wdcl_host_i.q, 32'h01);
    units_us = 1'b0;
    set(4'h8);
    for (i = 0; i < 200 && underflow_reset !== 1'b1; i = i + 1)
      @(posedge clk_sys) #1;
    chk(underflow_reset, 32'h1);
    set(4'h0);
    set(4'h2);
    set(4'h0);
    chk(underflow_reset_flag, 32'h1);
    set(4'h3);
    set(4'h0);
    chk(underflow_reset_flag, 32'h0);
    final_report;
  end
endmodule
